// >>> src/hdc_holdover_dac_control.sv
// Holdover DAC control: manual/tracked DAC selection, rail trips, tracking rate,
// AXI4-Lite register slave and a read-to-clear interrupt status.
// Assumes pins PD_CLK, PLL1_LOCK and TUNE_LEVEL come from outside this clock.
//
// Function
// - In holdover with manual mode chosen, the DAC is driven by the manual value, not the tracked one.
// - The manual value is the two low bits of the first control register above all eight bits of the next.
// - The six-bit floor field sets a trip at (code+1)/64 of supply; at or below it, rails enabled, holdover begins.
// - The six-bit ceiling field sets a trip (code+1)/64 below supply; reaching it, rails enabled, holdover begins.
// - The two-bit multiplier selects 4, 64, 1024 or 16384 for codes 0 to 3.
// - The eight-bit rate count resets to 127 and the update interval is multiplier times count phase-detector periods.
// - One manual-select bit picks tracked operation when clear and manual operation when set.
// - With tracking on, the DAC follows the loop tuning only while locked, starting from code 512 after reset.
// - A rail trip with rail detection on marks the input clock invalid and raises a clock switch event.
`timescale 1ns/1ps
module hdc_holdover_dac_control (
  input  wire logic        CORE_CLK,
  input  wire logic        RST,
  // AXI4-Lite slave
  input  wire logic [11:0] S_AXI_AWADDR,
  input  wire logic        S_AXI_AWVALID,
  output logic             S_AXI_AWREADY,
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  input  wire logic        S_AXI_WVALID,
  output logic             S_AXI_WREADY,
  output logic [1:0]       S_AXI_BRESP,
  output logic             S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  input  wire logic [11:0] S_AXI_ARADDR,
  input  wire logic        S_AXI_ARVALID,
  output logic             S_AXI_ARREADY,
  output logic [31:0]      S_AXI_RDATA,
  output logic [1:0]       S_AXI_RRESP,
  output logic             S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY,
  // Loop side
  input  wire logic        PD_CLK,
  input  wire logic        PLL1_LOCK,
  input  wire logic [9:0]  TUNE_LEVEL,
  output logic [9:0]       DAC_CODE,
  output logic             HOLDOVER,
  output logic             CLK_SWITCH_EVENT,
  output logic             IRQ
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  logic [7:0]                 ctrl_q, ctrl_d;
  logic [7:0]                 man_lo_q, man_lo_d;
  logic [5:0]                 floor_q, floor_d;
  logic [7:0]                 mult_ceil_q, mult_ceil_d;
  logic [7:0]                 rate_cnt_q, rate_cnt_d;
  logic                       rail_en_q, rail_en_d;
  logic [hdc_pkg::IRQ_W-1:0]  status_q, status_d;
  logic [hdc_pkg::IRQ_W-1:0]  mask_q, mask_d;
  logic [9:0]                 tracked_q, tracked_d;
  logic [hdc_pkg::INTERVAL_W-1:0] ivl_q, ivl_d;
  logic                       trip_q, trip_d;
  logic                       hold_q, hold_d;
  logic                       event_q, event_d;
  logic [9:0]                 dac_q, dac_d;
  logic [2:0]                 pd_sync_q, pd_sync_d;
  logic [1:0]                 lock_sync_q, lock_sync_d;
  logic                       lock_prev_q, lock_prev_d;
  logic [9:0]                 tune_s1_q, tune_s1_d;
  logic [9:0]                 tune_q, tune_d;
  hdc_pkg::hdc_bus_state_t    wst_q, wst_d;
  hdc_pkg::hdc_bus_state_t    rst_q, rst_d;
  logic                       aw_got_q, aw_got_d;
  logic                       w_got_q, w_got_d;
  logic [11:0]                awaddr_q, awaddr_d;
  logic [31:0]                wdata_q, wdata_d;
  logic [3:0]                 wstrb_q, wstrb_d;
  logic [1:0]                 bresp_q, bresp_d;
  logic [31:0]                rdata_q, rdata_d;
  logic [1:0]                 rresp_q, rresp_d;

  // Combinational helpers
  logic                       pd_tick;
  logic [4:0]                 shift;
  logic [hdc_pkg::INTERVAL_W-1:0] interval;
  logic                       expire;
  logic                       locked;
  logic [5:0]                 upper6;
  logic                       trip_now;
  logic                       trip_rise;
  logic                       do_write;
  logic [9:0]                 widx;
  logic [9:0]                 ridx;
  logic                       rd_take;
  logic                       rd_status;
  logic [31:0]                rword;
  logic                       wmapped;
  logic                       rmapped;
  logic [9:0]                 man_value;

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  always_comb begin
    // Pin synchronisers; the second stage is read, and PD_CLK also its third for the edge
    pd_sync_d   = {pd_sync_q[1:0], PD_CLK};
    lock_sync_d = {lock_sync_q[0], PLL1_LOCK};
    tune_s1_d   = TUNE_LEVEL;
    tune_d      = tune_s1_q;
    pd_tick     = pd_sync_q[1] & ~pd_sync_q[2];
    locked      = lock_sync_q[1];
    lock_prev_d = locked;

    man_value   = {ctrl_q[1:0], man_lo_q};

    // Interval = multiplier * count in phase-detector periods
    case (mult_ceil_q[7:6])
      2'h0:    shift = hdc_pkg::MULT_SHIFT_0;
      2'h1:    shift = hdc_pkg::MULT_SHIFT_1;
      2'h2:    shift = hdc_pkg::MULT_SHIFT_2;
      2'h3:    shift = hdc_pkg::MULT_SHIFT_3;
      default: shift = hdc_pkg::MULT_SHIFT_0;
    endcase
    interval = hdc_pkg::INTERVAL_W'({16'h0000, rate_cnt_q}) << shift;
    // A zero count would never expire; treat it as every tick
    expire   = pd_tick && ((ivl_q + 1'b1) >= interval);
    ivl_d    = ivl_q;
    if (pd_tick) begin
      ivl_d = expire ? '0 : ivl_q + 1'b1;
    end

    // Tracking steps one code per expiry, only while locked
    tracked_d = tracked_q;
    if (expire && ctrl_q[hdc_pkg::BIT_TRACK_EN] && locked) begin
      if (tune_q > tracked_q) begin
        tracked_d = tracked_q + 10'h001;
      end else if (tune_q < tracked_q) begin
        tracked_d = tracked_q - 10'h001;
      end
    end

    // Rail trips on the upper six bits of the tracked code
    upper6    = tracked_q[9:4];
    trip_now  = rail_en_q && ((upper6 <= floor_q) ||
                (upper6 >= (6'h3f - mult_ceil_q[5:0])));
    trip_d    = trip_now;
    trip_rise = trip_now & ~trip_q;
    event_d   = trip_rise;

    // Holdover latches on a trip until software releases it
    hold_d = hold_q | trip_rise;

    // Manual value only while in holdover and manual selected
    if ((hold_q || ctrl_q[hdc_pkg::BIT_HOLD_FORCE]) && ctrl_q[hdc_pkg::BIT_MAN_SELECT]) begin
      dac_d = man_value;
    end else begin
      dac_d = tracked_q;
    end

    // --- Write channel: address and data taken in either order
    aw_got_d = aw_got_q;
    w_got_d  = w_got_q;
    awaddr_d = awaddr_q;
    wdata_d  = wdata_q;
    wstrb_d  = wstrb_q;
    wst_d    = wst_q;
    bresp_d  = bresp_q;
    S_AXI_AWREADY = (wst_q == hdc_pkg::HDC_BUS_IDLE) && !aw_got_q;
    S_AXI_WREADY  = (wst_q == hdc_pkg::HDC_BUS_IDLE) && !w_got_q;
    if (S_AXI_AWVALID && S_AXI_AWREADY) begin
      aw_got_d = 1'b1;
      awaddr_d = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && S_AXI_WREADY) begin
      w_got_d = 1'b1;
      wdata_d = S_AXI_WDATA;
      wstrb_d = S_AXI_WSTRB;
    end
    widx     = awaddr_q[11:2];
    do_write = (wst_q == hdc_pkg::HDC_BUS_IDLE) && aw_got_q && w_got_q;
    wmapped  = (awaddr_q[1:0] == 2'h0) &&
               ((widx >= hdc_pkg::IDX_HOLDOVER_CTRL_MANUAL_UPPER && widx <= hdc_pkg::IDX_TRACKING_RATE_COUNT) ||
                (widx >= hdc_pkg::IDX_RAIL_CTRL && widx <= hdc_pkg::IDX_DAC_STATE));
    case (wst_q)
      hdc_pkg::HDC_BUS_IDLE: begin
        if (do_write) begin
          wst_d    = hdc_pkg::HDC_BUS_RESP;
          aw_got_d = 1'b0;
          w_got_d  = 1'b0;
          bresp_d  = wmapped ? hdc_pkg::RESP_OKAY : hdc_pkg::RESP_DECERR;
        end
      end
      hdc_pkg::HDC_BUS_RESP: begin
        if (S_AXI_BREADY) begin
          wst_d = hdc_pkg::HDC_BUS_IDLE;
        end
      end
      default: wst_d = hdc_pkg::HDC_BUS_IDLE;
    endcase

    // Register writes; only byte lane 0 carries data
    ctrl_d      = ctrl_q;
    man_lo_d    = man_lo_q;
    floor_d     = floor_q;
    mult_ceil_d = mult_ceil_q;
    rate_cnt_d  = rate_cnt_q;
    rail_en_d   = rail_en_q;
    mask_d      = mask_q;
    if (do_write && wmapped && wstrb_q[0]) begin
      case (widx)
        hdc_pkg::IDX_HOLDOVER_CTRL_MANUAL_UPPER: ctrl_d      = wdata_q[7:0];
        hdc_pkg::IDX_MANUAL_LEVEL_LOWER:         man_lo_d    = wdata_q[7:0];
        hdc_pkg::IDX_TRIP_FLOOR:                 floor_d     = wdata_q[5:0];
        hdc_pkg::IDX_RATE_MULT_TRIP_CEILING:     mult_ceil_d = wdata_q[7:0];
        hdc_pkg::IDX_TRACKING_RATE_COUNT:        rate_cnt_d  = wdata_q[7:0];
        hdc_pkg::IDX_IRQ_MASK:                   mask_d      = wdata_q[hdc_pkg::IRQ_W-1:0];
        hdc_pkg::IDX_RAIL_CTRL: begin
          rail_en_d = wdata_q[hdc_pkg::BIT_RAIL_EN];
          // Release is ignored only in a cycle with a new trip edge, so a rising trip wins
          if (wdata_q[hdc_pkg::BIT_HOLD_RELEASE] && !trip_rise) begin
            hold_d = 1'b0;
          end
        end
        default: ;
      endcase
    end

    // --- Read channel: one read at a time, answer the cycle after
    rst_d   = rst_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    S_AXI_ARREADY = (rst_q == hdc_pkg::HDC_BUS_IDLE);
    rd_take = S_AXI_ARVALID && S_AXI_ARREADY;
    ridx    = S_AXI_ARADDR[11:2];
    rmapped = 1'b1;
    case (ridx)
      hdc_pkg::IDX_HOLDOVER_CTRL_MANUAL_UPPER: rword = {24'h000000, ctrl_q};
      hdc_pkg::IDX_MANUAL_LEVEL_LOWER:         rword = {24'h000000, man_lo_q};
      hdc_pkg::IDX_TRIP_FLOOR:                 rword = {26'h0, floor_q};
      hdc_pkg::IDX_RATE_MULT_TRIP_CEILING:     rword = {24'h000000, mult_ceil_q};
      hdc_pkg::IDX_TRACKING_RATE_COUNT:        rword = {24'h000000, rate_cnt_q};
      hdc_pkg::IDX_RAIL_CTRL:                  rword = {30'h0, hold_q, rail_en_q};
      hdc_pkg::IDX_IRQ_STATUS:                 rword = {29'h0, status_q};
      hdc_pkg::IDX_IRQ_MASK:                   rword = {29'h0, mask_q};
      hdc_pkg::IDX_DAC_STATE:                  rword = {6'h00, tracked_q, 6'h00, dac_q};
      default: begin
        rword   = 32'h00000000;
        rmapped = 1'b0;
      end
    endcase
    if (S_AXI_ARADDR[1:0] != 2'h0) begin
      rmapped = 1'b0;
      rword   = 32'h00000000;
    end
    rd_status = rd_take && rmapped && (ridx == hdc_pkg::IDX_IRQ_STATUS);
    case (rst_q)
      hdc_pkg::HDC_BUS_IDLE: begin
        if (rd_take) begin
          rst_d   = hdc_pkg::HDC_BUS_RESP;
          rdata_d = rword;
          rresp_d = rmapped ? hdc_pkg::RESP_OKAY : hdc_pkg::RESP_DECERR;
        end
      end
      hdc_pkg::HDC_BUS_RESP: begin
        if (S_AXI_RREADY) begin
          rst_d = hdc_pkg::HDC_BUS_IDLE;
        end
      end
      default: rst_d = hdc_pkg::HDC_BUS_IDLE;
    endcase

    // Sticky status: read clears, a new event in the same cycle survives
    status_d = rd_status ? '0 : status_q;
    status_d[hdc_pkg::BIT_ST_TRIP]      = status_d[hdc_pkg::BIT_ST_TRIP] | trip_rise;
    status_d[hdc_pkg::BIT_ST_UPDATE]    = status_d[hdc_pkg::BIT_ST_UPDATE] | (tracked_d != tracked_q);
    status_d[hdc_pkg::BIT_ST_LOCK_LOST] = status_d[hdc_pkg::BIT_ST_LOCK_LOST] | (lock_prev_q & ~locked);
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  // Reset loads constants only
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      ctrl_q      <= hdc_pkg::RST_CTRL_MANUAL_UPPER;
      man_lo_q    <= hdc_pkg::RST_MANUAL_LOWER;
      floor_q     <= hdc_pkg::RST_TRIP_FLOOR[5:0];
      mult_ceil_q <= hdc_pkg::RST_RATE_MULT_CEIL;
      rate_cnt_q  <= hdc_pkg::RST_RATE_COUNT;
      rail_en_q   <= 1'b0;
      status_q    <= '0;
      mask_q      <= '0;
      tracked_q   <= hdc_pkg::RST_TRACKED_CODE;
      ivl_q       <= '0;
      trip_q      <= 1'b0;
      hold_q      <= 1'b0;
      event_q     <= 1'b0;
      dac_q       <= hdc_pkg::RST_TRACKED_CODE;
      pd_sync_q   <= '0;
      lock_sync_q <= '0;
      lock_prev_q <= 1'b0;
      tune_s1_q   <= '0;
      tune_q      <= '0;
      wst_q       <= hdc_pkg::HDC_BUS_IDLE;
      rst_q       <= hdc_pkg::HDC_BUS_IDLE;
      aw_got_q    <= 1'b0;
      w_got_q     <= 1'b0;
      awaddr_q    <= '0;
      wdata_q     <= '0;
      wstrb_q     <= '0;
      bresp_q     <= hdc_pkg::RESP_OKAY;
      rdata_q     <= '0;
      rresp_q     <= hdc_pkg::RESP_OKAY;
    end else begin
      ctrl_q      <= ctrl_d;
      man_lo_q    <= man_lo_d;
      floor_q     <= floor_d;
      mult_ceil_q <= mult_ceil_d;
      rate_cnt_q  <= rate_cnt_d;
      rail_en_q   <= rail_en_d;
      status_q    <= status_d;
      mask_q      <= mask_d;
      tracked_q   <= tracked_d;
      ivl_q       <= ivl_d;
      trip_q      <= trip_d;
      hold_q      <= hold_d;
      event_q     <= event_d;
      dac_q       <= dac_d;
      pd_sync_q   <= pd_sync_d;
      lock_sync_q <= lock_sync_d;
      lock_prev_q <= lock_prev_d;
      tune_s1_q   <= tune_s1_d;
      tune_q      <= tune_d;
      wst_q       <= wst_d;
      rst_q       <= rst_d;
      aw_got_q    <= aw_got_d;
      w_got_q     <= w_got_d;
      awaddr_q    <= awaddr_d;
      wdata_q     <= wdata_d;
      wstrb_q     <= wstrb_d;
      bresp_q     <= bresp_d;
      rdata_q     <= rdata_d;
      rresp_q     <= rresp_d;
    end
  end

  // Outputs from flip-flops
  assign S_AXI_BVALID     = (wst_q == hdc_pkg::HDC_BUS_RESP);
  assign S_AXI_BRESP      = bresp_q;
  assign S_AXI_RVALID     = (rst_q == hdc_pkg::HDC_BUS_RESP);
  assign S_AXI_RDATA      = rdata_q;
  assign S_AXI_RRESP      = rresp_q;
  assign DAC_CODE         = dac_q;
  assign HOLDOVER         = hold_q | ctrl_q[hdc_pkg::BIT_HOLD_FORCE];
  assign CLK_SWITCH_EVENT = event_q;
  assign IRQ              = |(status_q & mask_q);
endmodule

// >>> src/hdc_pkg.sv
// Holdover DAC control: register map, field layout, reset values, timing.
// Assumes a 32-bit AXI4-Lite bus with one register per aligned word.
package hdc_pkg;
  // ----------------------------------------
  // Register indices (byte address = 4 * index)
  // ----------------------------------------
  localparam logic [9:0] IDX_HOLDOVER_CTRL_MANUAL_UPPER = 10'h14b;
  localparam logic [9:0] IDX_MANUAL_LEVEL_LOWER         = 10'h14c;
  localparam logic [9:0] IDX_TRIP_FLOOR                 = 10'h14d;
  localparam logic [9:0] IDX_RATE_MULT_TRIP_CEILING     = 10'h14e;
  localparam logic [9:0] IDX_TRACKING_RATE_COUNT        = 10'h14f;
  localparam logic [9:0] IDX_RAIL_CTRL                  = 10'h160;
  localparam logic [9:0] IDX_IRQ_STATUS                 = 10'h161;
  localparam logic [9:0] IDX_IRQ_MASK                   = 10'h162;
  localparam logic [9:0] IDX_DAC_STATE                  = 10'h163;
  localparam int         ADDR_W                         = 12;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int BIT_TRACK_EN      = 4;
  localparam int BIT_HOLD_FORCE    = 3;
  localparam int BIT_MAN_SELECT    = 2;
  localparam int BIT_RAIL_EN       = 0;
  localparam int BIT_HOLD_RELEASE  = 1;
  localparam int BIT_ST_TRIP       = 0;
  localparam int BIT_ST_UPDATE     = 1;
  localparam int BIT_ST_LOCK_LOST  = 2;
  localparam int IRQ_W             = 3;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [7:0] RST_CTRL_MANUAL_UPPER = 8'h16;
  localparam logic [7:0] RST_MANUAL_LOWER      = 8'h00;
  localparam logic [7:0] RST_TRIP_FLOOR        = 8'h00;
  localparam logic [7:0] RST_RATE_MULT_CEIL    = 8'h00;
  localparam logic [7:0] RST_RATE_COUNT        = 8'h7f;
  localparam logic [9:0] RST_TRACKED_CODE      = 10'h200;

  // Multiplier 4/64/1024/16384 as shift amounts
  localparam logic [4:0] MULT_SHIFT_0 = 5'h02;
  localparam logic [4:0] MULT_SHIFT_1 = 5'h06;
  localparam logic [4:0] MULT_SHIFT_2 = 5'h0a;
  localparam logic [4:0] MULT_SHIFT_3 = 5'h0e;
  localparam int         INTERVAL_W   = 24;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  typedef enum logic [1:0] {
    HDC_BUS_IDLE = 2'b00,
    HDC_BUS_RESP = 2'b01
  } hdc_bus_state_t;
endpackage

// >>> dv/hdc_holdover_dac_control_monitor.sv
// Checker for the holdover DAC block: drive choice, tracking, trips, irq.
// Assumes only the top ports; bound to every instance at the foot.
`timescale 1ns/1ps
module hdc_holdover_dac_control_monitor (
  input wire logic        CORE_CLK,
  input wire logic        RST,
  input wire logic [11:0] S_AXI_AWADDR,
  input wire logic        S_AXI_AWVALID,
  input wire logic        S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0]  S_AXI_WSTRB,
  input wire logic        S_AXI_WVALID,
  input wire logic        S_AXI_WREADY,
  input wire logic [1:0]  S_AXI_BRESP,
  input wire logic        S_AXI_BVALID,
  input wire logic        PLL1_LOCK,
  input wire logic [9:0]  DAC_CODE,
  input wire logic        HOLDOVER,
  input wire logic        CLK_SWITCH_EVENT,
  input wire logic        IRQ
);
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RST);
  logic [11:0] aw_q;
  logic [8:0]  w_q;
  logic        bv_q;
  logic        hold_q;
  logic [7:0]  ctrl_q;
  logic [7:0]  low_q;
  logic        mask_q;
  logic [1:0]  quiet_q;
  logic        commit;
  assign commit = S_AXI_BVALID && !bv_q && S_AXI_BRESP == hdc_pkg::RESP_OKAY && w_q[8];
  // ----
  // Register shadow, one edge late; quiet counts cycles with no bus write and no holdover change
  // ----
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      aw_q    <= 12'h000;
      w_q     <= 9'h000;
      bv_q    <= 1'b0;
      hold_q  <= 1'b0;
      ctrl_q  <= hdc_pkg::RST_CTRL_MANUAL_UPPER;
      low_q   <= hdc_pkg::RST_MANUAL_LOWER;
      mask_q  <= 1'b0;
      quiet_q <= 2'h0;
    end else begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) aw_q <= S_AXI_AWADDR;
      if (S_AXI_WVALID && S_AXI_WREADY) w_q <= {S_AXI_WSTRB[0], S_AXI_WDATA[7:0]};
      bv_q   <= S_AXI_BVALID;
      hold_q <= HOLDOVER;
      if (commit && aw_q == 12'h52c) ctrl_q <= w_q[7:0];
      if (commit && aw_q == 12'h530) low_q <= w_q[7:0];
      if (commit && aw_q == 12'h588) mask_q <= w_q[0];
      // A pending write may move the drive before the shadow sees it
      if (!S_AXI_AWREADY || !S_AXI_WREADY || S_AXI_BVALID || HOLDOVER != hold_q) quiet_q <= 2'h0;
      else if (quiet_q != 2'h3) quiet_q <= quiet_q + 2'h1;
    end
  end
  // ----
  // Properties
  // ----
  property p_dac_reset;
    $past(RST) |-> DAC_CODE == hdc_pkg::RST_TRACKED_CODE;
  endproperty
  a_dac_reset: assert property (p_dac_reset) else $error("DAC code not at start after reset");
  property p_manual;
    quiet_q == 2'h3 && $stable(HOLDOVER) && HOLDOVER && ctrl_q[2] |-> DAC_CODE == {ctrl_q[1:0], low_q};
  endproperty
  a_manual: assert property (p_manual) else $error("DAC not at manual value in holdover");
  property p_step;
    quiet_q == 2'h3 && $stable(HOLDOVER) && !(HOLDOVER && ctrl_q[2]) |->
      DAC_CODE == $past(DAC_CODE) || DAC_CODE == $past(DAC_CODE) + 10'h1 || DAC_CODE == $past(DAC_CODE) - 10'h1;
  endproperty
  a_step: assert property (p_step) else $error("tracked DAC moved more than one step");
  property p_lock_hold;
    (!PLL1_LOCK)[*5] ##0 (quiet_q == 2'h3 && $stable(HOLDOVER) && !(HOLDOVER && ctrl_q[2])) |=> $stable(DAC_CODE);
  endproperty
  a_lock_hold: assert property (p_lock_hold) else $error("DAC tracked without lock");
  property p_event_hold;
    $rose(CLK_SWITCH_EVENT) |-> ##[0:1] HOLDOVER;
  endproperty
  a_event_hold: assert property (p_event_hold) else $error("switch event without holdover");
  property p_event_pulse;
    CLK_SWITCH_EVENT |=> !CLK_SWITCH_EVENT;
  endproperty
  a_event_pulse: assert property (p_event_pulse) else $error("switch event longer than a cycle");
  property p_irq;
    CLK_SWITCH_EVENT && mask_q |-> ##[0:2] IRQ;
  endproperty
  a_irq: assert property (p_irq) else $error("unmasked trip raised no interrupt");
  property p_bresp;
    S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY |=> !S_AXI_BVALID ##1 S_AXI_BVALID;
  endproperty
  a_bresp: assert property (p_bresp) else $error("write response not on time");
  c_manual: cover property (quiet_q == 2'h3 && HOLDOVER && ctrl_q[2]);
  c_event: cover property (CLK_SWITCH_EVENT);
  c_irq: cover property (IRQ);
endmodule

bind hdc_holdover_dac_control hdc_holdover_dac_control_monitor hdc_holdover_dac_control_monitor_inst (.*);

// >>> dv/hdc_holdover_dac_control_test.sv
// Self-checking bench for the holdover DAC block over its AXI4-Lite port.
// Assumes the checker is bound by its own file; one 200 MHz clock.
`timescale 1ns/1ps
module hdc_holdover_dac_control_test;
  logic        CORE_CLK = 1'b0;
  logic        RST = 1'b1;
  logic [11:0] S_AXI_AWADDR = 12'h000;
  logic        S_AXI_AWVALID = 1'b0;
  logic        S_AXI_AWREADY;
  logic [31:0] S_AXI_WDATA = 32'h0;
  logic [3:0]  S_AXI_WSTRB = 4'hf;
  logic        S_AXI_WVALID = 1'b0;
  logic        S_AXI_WREADY;
  logic [1:0]  S_AXI_BRESP;
  logic        S_AXI_BVALID;
  logic        S_AXI_BREADY = 1'b1;
  logic [11:0] S_AXI_ARADDR = 12'h000;
  logic        S_AXI_ARVALID = 1'b0;
  logic        S_AXI_ARREADY;
  logic [31:0] S_AXI_RDATA;
  logic [1:0]  S_AXI_RRESP;
  logic        S_AXI_RVALID;
  logic        S_AXI_RREADY = 1'b1;
  logic        PD_CLK = 1'b0;
  logic        PLL1_LOCK = 1'b1;
  logic [9:0]  TUNE_LEVEL = 10'h200;
  logic [9:0]  DAC_CODE;
  logic        HOLDOVER;
  logic        CLK_SWITCH_EVENT;
  logic        IRQ;
  logic [1:0]  pd_cnt = 2'h0;
  logic [31:0] d;
  logic [1:0]  resp;
  logic [9:0]  v;
  logic [5:0]  hi;
  int          errors = 0;
  int          compares = 0;
  logic [11:0] ra [3] = '{12'h530, 12'h538, 12'h53c};
  hdc_holdover_dac_control hdc_holdover_dac_control_inst (.*);
  // ----
  // Clocks: core clock, phase-detector edge every four core cycles
  // ----
  initial begin
    forever #2.5 CORE_CLK = ~CORE_CLK;
  end
  always @(posedge CORE_CLK) begin
    pd_cnt <= pd_cnt + 2'h1;
    PD_CLK <= pd_cnt[1];
  end
  // ----
  // Tasks
  // ----
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] x, output logic [1:0] r);
    int n;
    n = 0;
    S_AXI_AWADDR  <= a;
    S_AXI_AWVALID <= 1'b1;
    S_AXI_WDATA   <= x;
    S_AXI_WVALID  <= 1'b1;
    // Ready stays high, so the answer is taken at the edge it is seen
    do begin
      @(posedge CORE_CLK);
      n++;
      if (S_AXI_AWREADY) S_AXI_AWVALID <= 1'b0;
      if (S_AXI_WREADY) S_AXI_WVALID <= 1'b0;
    end while (!S_AXI_BVALID && n < 100);
    // A write that never answers counts against the run
    if (!S_AXI_BVALID) errors++;
    r = S_AXI_BRESP;
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] x, output logic [1:0] r);
    int n;
    n = 0;
    S_AXI_ARADDR  <= a;
    S_AXI_ARVALID <= 1'b1;
    do begin
      @(posedge CORE_CLK);
      n++;
      if (S_AXI_ARREADY) S_AXI_ARVALID <= 1'b0;
    end while (!S_AXI_RVALID && n < 100);
    if (!S_AXI_RVALID) errors++;
    x = S_AXI_RDATA;
    r = S_AXI_RRESP;
  endtask
  task automatic rchk(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
    rd(a, d, resp);
    check("read data", d, e);
    check("read response", 32'(resp), 32'(er));
  endtask
  task automatic manual(input logic [9:0] m);
    wr(12'h52c, {26'h0, 4'h3, m[9:8]}, resp);
    wr(12'h530, {24'h0, m[7:0]}, resp);
    repeat (4) @(posedge CORE_CLK);
    check("manual drive", 32'(DAC_CODE), 32'(m));
  endtask
  task automatic rate(input logic [1:0] m, input logic [7:0] c);
    int n;
    wr(12'h538, {24'h0, m, 6'h00}, resp);
    wr(12'h53c, {24'h0, c}, resp);
    // First change realigns the interval, the second is timed
    for (int k = 0; k < 2; k++) begin
      v = DAC_CODE;
      n = 0;
      while (DAC_CODE === v && n < 9000) begin
        @(posedge CORE_CLK);
        n++;
      end
    end
    check("update interval", 32'(n), 32'((4 << (4 * m)) * c * 4));
    check("tracked step", 32'(DAC_CODE), 32'(v) + 32'h1);
  endtask
  task automatic trip(input logic [11:0] a, input logic [5:0] t, input logic exp);
    logic seen;
    seen = 1'b0;
    wr(a, {26'h0, t}, resp);
    repeat (6) begin
      @(posedge CORE_CLK);
      seen |= CLK_SWITCH_EVENT;
    end
    check("switch event", 32'(seen), 32'(exp));
    check("holdover", 32'(HOLDOVER), 32'(exp));
  endtask
  task automatic close_out();
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // Hang guard, well past the longest timed interval
  initial begin
    repeat (60000) @(posedge CORE_CLK);
    errors++;
    close_out();
  end
  // ----
  // Main sequence
  // ----
  initial begin
    void'($urandom(19580));
    repeat (16) @(posedge CORE_CLK);
    RST <= 1'b0;
    rchk(12'h52c, 32'(hdc_pkg::RST_CTRL_MANUAL_UPPER), hdc_pkg::RESP_OKAY);
    rchk(12'h530, 32'h0, hdc_pkg::RESP_OKAY);
    rchk(12'h534, 32'h0, hdc_pkg::RESP_OKAY);
    rchk(12'h538, 32'h0, hdc_pkg::RESP_OKAY);
    rchk(12'h53c, 32'h7f, hdc_pkg::RESP_OKAY);
    rchk(12'h58c, 32'h0200_0200, hdc_pkg::RESP_OKAY);
    rchk(12'hffc, 32'h0, hdc_pkg::RESP_DECERR);
    wr(12'hffc, 32'h1, resp);
    check("write response", 32'(resp), 32'(hdc_pkg::RESP_DECERR));
    foreach (ra[i]) begin
      d = $urandom;
      wr(ra[i], d, resp);
      rchk(ra[i], {24'h0, d[7:0]}, hdc_pkg::RESP_OKAY);
    end
    $display("test registers done");
    manual(10'h000);
    manual(10'h3ff);
    manual(10'($urandom));
    wr(12'h52c, 32'h08, resp);
    repeat (4) @(posedge CORE_CLK);
    check("tracked in holdover", 32'(DAC_CODE), 32'h200);
    wr(12'h52c, 32'h04, resp);
    repeat (4) @(posedge CORE_CLK);
    check("manual outside holdover", 32'(DAC_CODE), 32'h200);
    $display("test manual done");
    TUNE_LEVEL <= 10'(600 + $urandom_range(300));
    wr(12'h52c, 32'h10, resp);
    rate(2'h0, 8'h01);
    rate(2'h0, 8'h03);
    rate(2'h1, 8'h01);
    rate(2'h2, 8'h01);
    // Fast rate again, so a step without lock would show within the wait
    wr(12'h538, 32'h0, resp);
    PLL1_LOCK <= 1'b0;
    repeat (8) @(posedge CORE_CLK);
    v = DAC_CODE;
    repeat (100) @(posedge CORE_CLK);
    check("hold without lock", 32'(DAC_CODE), 32'(v));
    $display("test tracking done");
    rchk(12'h584, 32'h6, hdc_pkg::RESP_OKAY);
    rd(12'h58c, d, resp);
    hi = d[25:20];
    wr(12'h588, 32'h1, resp);
    wr(12'h580, 32'h1, resp);
    trip(12'h534, hi - 6'h1, 1'b0);
    trip(12'h534, hi, 1'b1);
    check("irq raised", 32'(IRQ), 32'h1);
    rd(12'h584, d, resp);
    check("trip status", 32'(d[0]), 32'h1);
    repeat (2) @(posedge CORE_CLK);
    check("irq cleared", 32'(IRQ), 32'h0);
    wr(12'h534, 32'h0, resp);
    wr(12'h580, 32'h3, resp);
    repeat (2) @(posedge CORE_CLK);
    check("holdover released", 32'(HOLDOVER), 32'h0);
    wr(12'h588, 32'h0, resp);
    trip(12'h538, 6'd62 - hi, 1'b0);
    trip(12'h538, 6'd63 - hi, 1'b1);
    check("irq masked", 32'(IRQ), 32'h0);
    $display("test trips done");
    close_out();
  end
endmodule
